// ==== shared/pcd_pkg.sv ====
// constants shared by the peak and crossing detector block
// How it works
// RULE_01: upper set levels raise the peak flags
// RULE_02: flag clears after hold-off count below clear level
// RULE_03: software zeroes hold-off when crossing detector used
// RULE_04: select 0 feeds high comparators to filter
// RULE_05: select 1 feeds three-level minus/zero/plus input
// RULE_06: crossing period is two to the N cycles
// RULE_07: crossing fraction compared to signed 2.14 limits
// RULE_08: detector runs only while enable bit set
// RULE_09: block levels compared on 0 to 256 scale
// RULE_10: two-level enable picks one- or two-bit output
// RULE_11: unused upper bits ignored and read as zero
package pcd_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE     = 8'h00;
  localparam logic [7:0] IDX_SET_A      = 8'h07;
  localparam logic [7:0] IDX_CLR_A      = 8'h08;
  localparam logic [7:0] IDX_SET_B      = 8'h09;
  localparam logic [7:0] IDX_CLR_B      = 8'h0a;
  localparam logic [7:0] IDX_HOLD0      = 8'h0b;
  localparam logic [7:0] IDX_HOLD1      = 8'h0c;
  localparam logic [7:0] IDX_IIR_SEL    = 8'h0d;
  localparam logic [7:0] IDX_PERIOD_EXP = 8'h0e;
  localparam logic [7:0] IDX_P0_UP_LO   = 8'h0f;
  localparam logic [7:0] IDX_P0_UP_HI   = 8'h10;
  localparam logic [7:0] IDX_P0_LO_LO   = 8'h11;
  localparam logic [7:0] IDX_P0_LO_HI   = 8'h12;
  localparam logic [7:0] IDX_P0_TWO_LVL = 8'h13;
  localparam logic [7:0] IDX_P1_UP_LO   = 8'h16;
  localparam logic [7:0] IDX_P1_UP_HI   = 8'h17;
  localparam logic [7:0] IDX_P1_LO_LO   = 8'h18;
  localparam logic [7:0] IDX_P1_LO_HI   = 8'h19;
  localparam logic [7:0] IDX_P1_TWO_LVL = 8'h1a;
  localparam logic [7:0] IDX_IRQ_STAT   = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h31;
  localparam logic [7:0] IDX_LIVE       = 8'h32;
  localparam int         IDX_LSB        = 2;
  localparam int         IDX_MSB        = 9;
  // field widths and reset values
  localparam int         PEAK_W         = 9;
  localparam int         HOLD_W         = 16;
  localparam int         EXP_W          = 4;
  localparam int         LIM_W          = 16;
  localparam int         FRAC_SHIFT     = 14;
  localparam int         NUM_EVT        = 4;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0] HTRANS_SEQ     = 2'h3;
  // three-level filter input codes
  localparam logic [1:0] IIR_PLUS       = 2'h1;
  localparam logic [1:0] IIR_ZERO       = 2'h0;
  localparam logic [1:0] IIR_MINUS      = 2'h3;
  typedef enum logic {BUS_IDLE, BUS_RD_WAIT} pcd_bus_t;
endpackage

// ==== src/pcd_hyst.sv ====
// one hysteresis flag with hold-off count
`timescale 1ns/1ps
module pcd_hyst #(
  parameter int HW = 16
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_run,
  input  wire logic          i_above,
  input  wire logic          i_below,
  input  wire logic [HW-1:0] i_hold,
  output logic               o_flag
);
  logic [HW-1:0] cnt_r;
  logic          flag_r;
  wire           sat = &cnt_r;
  // clear only after the hold count of consecutive cycles below
  wire           clr = flag_r & i_below & (cnt_r >= i_hold); // RULE_02

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_r <= 1'b0;
      cnt_r  <= '0;
    end else if (!i_run) begin // RULE_08
      flag_r <= 1'b0;
      cnt_r  <= '0;
    end else if (i_above) begin
      flag_r <= 1'b1; // RULE_01
      cnt_r  <= '0;
    end else if (clr) begin
      flag_r <= 1'b0;
      cnt_r  <= '0;
    end else if (flag_r && i_below) begin
      cnt_r  <= sat ? cnt_r : cnt_r + 1'b1;
    end else begin
      cnt_r  <= '0; // any cycle not below restarts the count
    end
  end

  assign o_flag = flag_r;
endmodule // pcd_hyst

// ==== src/pcd_top.sv ====
// peak and crossing detector with its register slave
`timescale 1ns/1ps
module pcd_top (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_hsel,
  input  wire logic [31:0]                i_haddr,
  input  wire logic [1:0]                 i_htrans,
  input  wire logic                       i_hwrite,
  input  wire logic [2:0]                 i_hsize,
  input  wire logic [31:0]                i_hwdata,
  input  wire logic                       i_hready,
  output logic      [31:0]                o_hrdata,
  output logic                            o_hreadyout,
  output logic                            o_hresp,
  input  wire logic [pcd_pkg::PEAK_W-1:0] i_blk_peak,
  input  wire logic [1:0]                 i_path_cross,
  output logic      [1:0]                 o_peak_flag,
  output logic      [1:0]                 o_iir_in,
  output logic      [1:0]                 o_path0_cmp,
  output logic      [1:0]                 o_path1_cmp,
  output logic                            o_irq
);
  import pcd_pkg::*;

  // configuration storage
  logic              enable_r;
  logic [7:0]        set_a_r;
  logic [7:0]        clr_a_r;
  logic [7:0]        set_b_r;
  logic [7:0]        clr_b_r;
  logic [HOLD_W-1:0] hold_r;
  logic              iir_sel_r;
  logic [EXP_W-1:0]  exp_r;
  logic [LIM_W-1:0]  up0_r;
  logic [LIM_W-1:0]  lo0_r;
  logic [LIM_W-1:0]  up1_r;
  logic [LIM_W-1:0]  lo1_r;
  logic [1:0]        two_lvl_r;
  logic [NUM_EVT-1:0] stat_r;
  logic [NUM_EVT-1:0] mask_r;

  // bus state
  pcd_bus_t          bus_r;
  logic              wr_ph_r;
  logic [7:0]        idx_r;
  logic              hit_r;
  logic [31:0]       hrdata_r;

  // address phase decode
  wire        addr_ok  = (i_haddr[31:IDX_MSB+1] == '0);
  wire [7:0]  a_idx    = i_haddr[IDX_MSB:IDX_LSB];
  wire        xfer     = i_hsel & i_hready & i_htrans[1];
  wire        rd_start = xfer & ~i_hwrite;
  wire        wr_start = xfer & i_hwrite;
  wire        wr_do    = wr_ph_r & hit_r;
  wire [7:0]  wb       = i_hwdata[7:0];

  // reads get one wait state so a write just before is visible
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_r   <= BUS_IDLE;
      wr_ph_r <= 1'b0;
      idx_r   <= '0;
      hit_r   <= 1'b0;
    end else begin
      wr_ph_r <= wr_start;
      if (xfer) begin
        idx_r <= a_idx;
        hit_r <= addr_ok;
      end
      unique case (bus_r)
        BUS_IDLE:    bus_r <= rd_start ? BUS_RD_WAIT : BUS_IDLE;
        BUS_RD_WAIT: bus_r <= BUS_IDLE;
      endcase
    end
  end

  assign o_hreadyout = (bus_r == BUS_IDLE);
  assign o_hresp     = 1'b0;

  // read selection; unused upper bits read as zero
  logic [31:0] rd_mux;
  wire  [1:0]  flags;
  wire  [1:0]  pflags;
  always_comb begin
    rd_mux = '0;
    if (hit_r) begin
      unique case (idx_r)
        IDX_ENABLE:     rd_mux[0]   = enable_r; // RULE_11
        IDX_SET_A:      rd_mux[7:0] = set_a_r;
        IDX_CLR_A:      rd_mux[7:0] = clr_a_r;
        IDX_SET_B:      rd_mux[7:0] = set_b_r;
        IDX_CLR_B:      rd_mux[7:0] = clr_b_r;
        IDX_HOLD0:      rd_mux[7:0] = hold_r[7:0];
        IDX_HOLD1:      rd_mux[7:0] = hold_r[15:8];
        IDX_IIR_SEL:    rd_mux[0]   = iir_sel_r;
        IDX_PERIOD_EXP: rd_mux[3:0] = exp_r;
        IDX_P0_UP_LO:   rd_mux[7:0] = up0_r[7:0];
        IDX_P0_UP_HI:   rd_mux[7:0] = up0_r[15:8];
        IDX_P0_LO_LO:   rd_mux[7:0] = lo0_r[7:0];
        IDX_P0_LO_HI:   rd_mux[7:0] = lo0_r[15:8];
        IDX_P0_TWO_LVL: rd_mux[0]   = two_lvl_r[0];
        IDX_P1_UP_LO:   rd_mux[7:0] = up1_r[7:0];
        IDX_P1_UP_HI:   rd_mux[7:0] = up1_r[15:8];
        IDX_P1_LO_LO:   rd_mux[7:0] = lo1_r[7:0];
        IDX_P1_LO_HI:   rd_mux[7:0] = lo1_r[15:8];
        IDX_P1_TWO_LVL: rd_mux[0]   = two_lvl_r[1];
        IDX_IRQ_STAT:   rd_mux[3:0] = stat_r;
        IDX_IRQ_MASK:   rd_mux[3:0] = mask_r;
        IDX_LIVE:       rd_mux[3:0] = {pflags, flags};
        default:        rd_mux      = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hrdata_r <= '0;
    end else if (bus_r == BUS_RD_WAIT) begin
      hrdata_r <= rd_mux;
    end
  end

  assign o_hrdata = hrdata_r;

  // write strobes per register
  wire w_en   = wr_do & (idx_r == IDX_ENABLE);
  wire w_sa   = wr_do & (idx_r == IDX_SET_A);
  wire w_ca   = wr_do & (idx_r == IDX_CLR_A);
  wire w_sb   = wr_do & (idx_r == IDX_SET_B);
  wire w_cb   = wr_do & (idx_r == IDX_CLR_B);
  wire w_h0   = wr_do & (idx_r == IDX_HOLD0);
  wire w_h1   = wr_do & (idx_r == IDX_HOLD1);
  wire w_sel  = wr_do & (idx_r == IDX_IIR_SEL);
  wire w_exp  = wr_do & (idx_r == IDX_PERIOD_EXP);
  wire w_u0l  = wr_do & (idx_r == IDX_P0_UP_LO);
  wire w_u0h  = wr_do & (idx_r == IDX_P0_UP_HI);
  wire w_l0l  = wr_do & (idx_r == IDX_P0_LO_LO);
  wire w_l0h  = wr_do & (idx_r == IDX_P0_LO_HI);
  wire w_t0   = wr_do & (idx_r == IDX_P0_TWO_LVL);
  wire w_u1l  = wr_do & (idx_r == IDX_P1_UP_LO);
  wire w_u1h  = wr_do & (idx_r == IDX_P1_UP_HI);
  wire w_l1l  = wr_do & (idx_r == IDX_P1_LO_LO);
  wire w_l1h  = wr_do & (idx_r == IDX_P1_LO_HI);
  wire w_t1   = wr_do & (idx_r == IDX_P1_TWO_LVL);
  wire w_stat = wr_do & (idx_r == IDX_IRQ_STAT);
  wire w_mask = wr_do & (idx_r == IDX_IRQ_MASK);

  // single-bit and narrow fields keep only their low bits
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_r  <= 1'b0;
      iir_sel_r <= 1'b0;
      exp_r     <= '0;
      two_lvl_r <= '0;
      mask_r    <= '0;
    end else begin
      if (w_en)   enable_r     <= wb[0]; // RULE_11
      if (w_sel)  iir_sel_r    <= wb[0];
      if (w_exp)  exp_r        <= wb[EXP_W-1:0];
      if (w_t0)   two_lvl_r[0] <= wb[0];
      if (w_t1)   two_lvl_r[1] <= wb[0];
      if (w_mask) mask_r       <= wb[NUM_EVT-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      set_a_r <= RST_BYTE;
      clr_a_r <= RST_BYTE;
      set_b_r <= RST_BYTE;
      clr_b_r <= RST_BYTE;
      hold_r  <= '0;
    end else begin
      if (w_sa) set_a_r      <= wb;
      if (w_ca) clr_a_r      <= wb;
      if (w_sb) set_b_r      <= wb;
      if (w_cb) clr_b_r      <= wb;
      if (w_h0) hold_r[7:0]  <= wb;
      if (w_h1) hold_r[15:8] <= wb;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up0_r <= '0;
      lo0_r <= '0;
      up1_r <= '0;
      lo1_r <= '0;
    end else begin
      if (w_u0l) up0_r[7:0]  <= wb;
      if (w_u0h) up0_r[15:8] <= wb;
      if (w_l0l) lo0_r[7:0]  <= wb;
      if (w_l0h) lo0_r[15:8] <= wb;
      if (w_u1l) up1_r[7:0]  <= wb;
      if (w_u1h) up1_r[15:8] <= wb;
      if (w_l1l) lo1_r[7:0]  <= wb;
      if (w_l1h) lo1_r[15:8] <= wb;
    end
  end

  // block level comparators; 8-bit levels widened onto the peak scale
  wire [PEAK_W-1:0] lvl_sa = {1'b0, set_a_r};
  wire [PEAK_W-1:0] lvl_ca = {1'b0, clr_a_r};
  wire [PEAK_W-1:0] lvl_sb = {1'b0, set_b_r};
  wire [PEAK_W-1:0] lvl_cb = {1'b0, clr_b_r};
  wire cmp_uh = i_blk_peak > lvl_sa; // RULE_09
  wire cmp_ul = i_blk_peak < lvl_ca;
  wire cmp_lh = i_blk_peak > lvl_sb;
  wire cmp_ll = i_blk_peak < lvl_cb;

  // crossing detector window of two to the N cycles
  logic [14:0]    win_r;
  logic [15:0]    xcnt_r [2];
  logic [LIM_W-1:0] frac_r [2];
  logic           fvld_r;
  wire  [14:0]    win_last = 15'((32'h1 << exp_r) - 1);
  wire            win_end  = (win_r == win_last); // RULE_06

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_r  <= '0;
      fvld_r <= 1'b0;
    end else if (!enable_r || win_end) begin // RULE_08
      win_r  <= '0;
      fvld_r <= enable_r;
    end else begin
      win_r  <= win_r + 1'b1;
    end
  end

  // per-path crossing count and its fraction of the window
  wire [LIM_W-1:0] up_lim [2];
  wire [LIM_W-1:0] lo_lim [2];
  wire [1:0]       p_above;
  wire [1:0]       p_below;
  assign up_lim[0] = up0_r;
  assign up_lim[1] = up1_r;
  assign lo_lim[0] = lo0_r;
  assign lo_lim[1] = lo1_r;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_path
      wire [15:0] cnt_now = xcnt_r[p] + 16'(i_path_cross[p]);
      // a count equal to the window length maps to 1.0 in 2.14
      wire [31:0] scaled  = ({16'h0, cnt_now} << FRAC_SHIFT) >> exp_r;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          xcnt_r[p] <= '0;
          frac_r[p] <= '0;
        end else if (!enable_r) begin
          xcnt_r[p] <= '0;
          frac_r[p] <= '0;
        end else if (win_end) begin
          xcnt_r[p] <= '0;
          frac_r[p] <= scaled[LIM_W-1:0]; // RULE_07
        end else begin
          xcnt_r[p] <= cnt_now;
        end
      end
      // limits are signed 2.14 values
      assign p_above[p] = fvld_r & ($signed(frac_r[p]) > $signed(up_lim[p])); // RULE_07
      assign p_below[p] = fvld_r & ($signed(frac_r[p]) < $signed(lo_lim[p]));
    end
  endgenerate

  // hysteresis flags: two block pairs then two crossing paths
  wire [3:0]        h_above = {p_above, cmp_lh, cmp_uh};
  wire [3:0]        h_below = {p_below, cmp_ll, cmp_ul};
  wire [3:0]        h_flag;
  wire [HOLD_W-1:0] h_hold [4];
  assign h_hold[0] = hold_r;
  assign h_hold[1] = hold_r;
  // the hold-off only applies to block flags; paths clear at once
  assign h_hold[2] = '0;
  assign h_hold[3] = '0;

  genvar h;
  generate
    for (h = 0; h < 4; h++) begin : g_hyst
      pcd_hyst #(
        .HW(HOLD_W)
      ) u_hyst (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_run  (enable_r),
        .i_above(h_above[h]), // RULE_01
        .i_below(h_below[h]), // RULE_02
        .i_hold (h_hold[h]),
        .o_flag (h_flag[h])
      );
    end
  endgenerate

  assign flags  = h_flag[1:0];
  assign pflags = h_flag[3:2];

  // filter input from the comparator flags
  wire [1:0] iir_two = flags[0] ? IIR_PLUS : (!flags[1] ? IIR_MINUS : IIR_ZERO); // RULE_05
  wire [1:0] iir_one = flags[0] ? IIR_PLUS : IIR_ZERO; // RULE_04
  wire [1:0] iir_nxt = !enable_r ? IIR_ZERO : (iir_sel_r ? iir_two : iir_one);

  // path comparator outputs: one-bit flag or above/below pair
  wire [1:0] cmp0_nxt = two_lvl_r[0] ? {p_above[0], p_below[0]} : {1'b0, pflags[0]}; // RULE_10
  wire [1:0] cmp1_nxt = two_lvl_r[1] ? {p_above[1], p_below[1]} : {1'b0, pflags[1]}; // RULE_10

  logic [1:0] iir_r;
  logic [1:0] cmp0_r;
  logic [1:0] cmp1_r;
  logic [1:0] flag_out_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      iir_r      <= IIR_ZERO;
      cmp0_r     <= '0;
      cmp1_r     <= '0;
      flag_out_r <= '0;
    end else begin
      iir_r      <= iir_nxt;
      cmp0_r     <= cmp0_nxt;
      cmp1_r     <= cmp1_nxt;
      flag_out_r <= flags;
    end
  end

  assign o_iir_in    = iir_r;
  assign o_path0_cmp = cmp0_r;
  assign o_path1_cmp = cmp1_r;
  assign o_peak_flag = flag_out_r;

  // interrupt events on rising flags; a set beats a same-cycle clear
  logic [3:0] flag_d_r;
  wire  [3:0] evt = h_flag & ~flag_d_r;
  wire  [3:0] clr = w_stat ? wb[NUM_EVT-1:0] : '0;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_d_r <= '0;
      stat_r   <= '0;
    end else begin
      flag_d_r <= h_flag;
      stat_r   <= (stat_r & ~clr) | evt;
    end
  end

  assign o_irq = |(stat_r & mask_r);
endmodule // pcd_top

// ==== tb/pcd_chk_sva.sv ====
// checker for bus timing and peak detector behaviour at the top ports
`timescale 1ns/1ps
module pcd_chk (
  input wire logic                       i_clk,
  input wire logic                       i_rst_n,
  input wire logic                       i_hsel,
  input wire logic [31:0]                i_haddr,
  input wire logic [1:0]                 i_htrans,
  input wire logic                       i_hwrite,
  input wire logic [31:0]                i_hwdata,
  input wire logic                       i_hready,
  input wire logic                       o_hreadyout,
  input wire logic [pcd_pkg::PEAK_W-1:0] i_blk_peak,
  input wire logic [1:0]                 o_peak_flag,
  input wire logic [1:0]                 o_iir_in,
  input wire logic [1:0]                 o_path1_cmp
);
  import pcd_pkg::*;
  logic        wp_r;
  logic [7:0]  wi_r;
  logic        en_m;
  logic        sel_m;
  logic        tl1_m;
  logic [7:0]  seta_m;
  logic [7:0]  clra_m;
  logic [15:0] hold_m;
  logic [16:0] below_cnt_r;
  wire logic   bus_req = i_hsel && i_hready && i_htrans[1];
  wire logic   above_a = i_blk_peak > {1'b0, seta_m};
  wire logic   below_a = i_blk_peak < {1'b0, clra_m};
  // mirror of the written settings, so the rules can be judged from the ports alone
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r <= 1'b0;
      wi_r <= 8'h00;
      {en_m, sel_m, tl1_m, seta_m, clra_m, hold_m} <= '0;
    end else begin
      wp_r <= bus_req && i_hwrite && (i_haddr[31:10] == 22'h0);
      wi_r <= i_haddr[9:2];
      if (wp_r && i_hready) begin
        case (wi_r)
          IDX_ENABLE:     en_m <= i_hwdata[0];
          IDX_IIR_SEL:    sel_m <= i_hwdata[0];
          IDX_P1_TWO_LVL: tl1_m <= i_hwdata[0];
          IDX_SET_A:      seta_m <= i_hwdata[7:0];
          IDX_CLR_A:      clra_m <= i_hwdata[7:0];
          IDX_HOLD0:      hold_m[7:0] <= i_hwdata[7:0];
          IDX_HOLD1:      hold_m[15:8] <= i_hwdata[7:0];
          default: ;
        endcase
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      below_cnt_r <= 17'h0;
    end else begin
      below_cnt_r <= (en_m && below_a) ? below_cnt_r + 17'h1 : 17'h0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd_req; bus_req && !i_hwrite; endsequence
  sequence s_one_wait; !o_hreadyout ##1 o_hreadyout; endsequence
  sequence s_up_held; (en_m && above_a) ##1 en_m [*2]; endsequence
  property p_wr_no_wait; bus_req && i_hwrite |=> o_hreadyout; endproperty
  property p_rd_one_wait; s_rd_req |=> s_one_wait; endproperty
  property p_set_upper; s_up_held |-> o_peak_flag[0]; endproperty
  property p_hold_min;
    $fell(o_peak_flag[0]) && en_m && $past(en_m) && $past(en_m, 2)
      |-> $past(below_cnt_r) > {1'b0, hold_m};
  endproperty
  property p_hold_max; below_cnt_r == {1'b0, hold_m} + 17'd2 |-> !o_peak_flag[0]; endproperty
  property p_sel_high;
    (en_m && !sel_m && $stable(o_peak_flag)) [*3]
      |-> o_iir_in == (o_peak_flag[0] ? IIR_PLUS : IIR_ZERO);
  endproperty
  property p_sel_three;
    (en_m && sel_m && $stable(o_peak_flag)) [*3]
      |-> o_iir_in == (o_peak_flag[0] ? IIR_PLUS : (o_peak_flag[1] ? IIR_ZERO : IIR_MINUS));
  endproperty
  property p_off; (!en_m) [*3] |-> o_peak_flag == 2'b00; endproperty
  property p_one_bit; !tl1_m && !$past(tl1_m) |-> !o_path1_cmp[1]; endproperty
  a_wr_no_wait: assert property (p_wr_no_wait) else $error("write data phase stalled");
  a_rd_one_wait: assert property (p_rd_one_wait) else $error("read wait state wrong");
  a_set_upper: assert property (p_set_upper) else $error("upper flag not set");
  a_hold_min: assert property (p_hold_min) else $error("flag cleared early");
  a_hold_max: assert property (p_hold_max) else $error("flag cleared late");
  a_sel_high: assert property (p_sel_high) else $error("filter input wrong");
  a_sel_three: assert property (p_sel_three) else $error("three level wrong");
  a_off: assert property (p_off) else $error("flags set while off");
  a_one_bit: assert property (p_one_bit) else $error("path1 not one bit");
endmodule // pcd_chk
bind pcd_top pcd_chk i_chk (.i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
  .i_hwdata, .i_hready, .o_hreadyout, .i_blk_peak, .o_peak_flag, .o_iir_in, .o_path1_cmp);

// ==== tb/pcd_agc_model.sv ====
// far-side model: feeds peak level and crossing events, counts upper alarms
`timescale 1ns/1ps
module pcd_agc_model (
  input  wire logic [8:0]                 i_level,
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic [1:0]                 i_cross_all,
  input  wire logic [1:0]                 i_cross_alt,
  input  wire logic [1:0]                 i_flag,
  output logic      [pcd_pkg::PEAK_W-1:0] o_peak,
  output logic      [1:0]                 o_cross,
  output logic      [7:0]                 o_alarm_cnt
);
  import pcd_pkg::*;
  logic       tog_r;
  logic       flag_q_r;
  // alternating events fill exactly half of any even window, whatever its phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_r <= 1'b0;
      flag_q_r <= 1'b0;
      o_alarm_cnt <= 8'h00;
    end else begin
      tog_r <= !tog_r;
      flag_q_r <= i_flag[0];
      if (i_flag[0] && !flag_q_r) o_alarm_cnt <= o_alarm_cnt + 8'h01;
    end
  end
  assign o_peak = i_level;
  assign o_cross = i_cross_all | (i_cross_alt & {2{tog_r}});
endmodule // pcd_agc_model

// ==== tb/pcd_top_tb.sv ====
// testbench for the peak and crossing detector
`timescale 1ns/1ps
module pcd_top_tb;
  import pcd_pkg::*;
  logic i_clk = 0, i_rst_n = 0, i_hsel = 0, i_hwrite = 0, o_hreadyout, o_hresp, o_irq;
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata;
  logic [1:0] i_htrans = 0, i_path_cross, o_peak_flag, o_iir_in, o_path0_cmp, o_path1_cmp;
  logic [1:0] call = 0, calt = 0;
  logic [8:0] i_blk_peak, level = 0;
  logic [7:0] alarm_cnt;
  int n_errors = 0, total_checks = 0, cycles = 0;
  logic [7:0] ridx [19] = '{IDX_SET_A, IDX_CLR_A, IDX_SET_B, IDX_CLR_B, IDX_HOLD0, IDX_HOLD1,
    IDX_IIR_SEL, IDX_PERIOD_EXP, IDX_P0_UP_LO, IDX_P0_UP_HI, IDX_P0_LO_LO, IDX_P0_LO_HI,
    IDX_P0_TWO_LVL, IDX_P1_UP_LO, IDX_P1_UP_HI, IDX_P1_LO_LO, IDX_P1_LO_HI, IDX_P1_TWO_LVL,
    IDX_IRQ_MASK};
  logic [7:0] rmsk [19] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h0f, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h0f};
  logic [7:0] cidx [8] = '{IDX_HOLD0, IDX_PERIOD_EXP, IDX_P0_UP_HI, IDX_P0_LO_HI,
    IDX_P0_TWO_LVL, IDX_P1_UP_HI, IDX_P1_LO_HI, IDX_ENABLE};
  logic [7:0] cdat [8] = '{8'h00, 8'h03, 8'h20, 8'h10, 8'h01, 8'h08, 8'h04, 8'h01};
  logic [1:0] pall [3] = '{2'b11, 2'b00, 2'b00};
  logic [1:0] palt [3] = '{2'b00, 2'b11, 2'b00};
  logic [1:0] e0 [3] = '{2'b10, 2'b00, 2'b01};
  logic [1:0] e1 [3] = '{2'b01, 2'b01, 2'b00};
  always #4 i_clk = ~i_clk;
  pcd_top i_dut (.i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2),
    .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_blk_peak,
    .i_path_cross, .o_peak_flag, .o_iir_in, .o_path0_cmp, .o_path1_cmp, .o_irq);
  pcd_agc_model i_agc (.i_level(level), .i_clk, .i_rst_n, .i_cross_all(call),
    .i_cross_alt(calt), .i_flag(o_peak_flag), .o_peak(i_blk_peak), .o_cross(i_path_cross),
    .o_alarm_cnt(alarm_cnt));
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    // ceiling sits well above the few hundred cycles the sequence needs
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    i_hsel <= 1'b1;
    i_haddr <= {22'h0, idx, 2'b00};
    i_htrans <= HTRANS_NONSEQ;
    i_hwrite <= wr;
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_clk);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= {24'h0, wd};
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_clk);
    rd = o_hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk($sformatf("reg %h", idx), {24'h0, e}, r);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  initial begin
    tick(6);
    i_rst_n <= 1'b1;
    tick(1);
    rchk(IDX_ENABLE, 8'h00);
    foreach (ridx[i]) rchk(ridx[i], 8'h00);
    foreach (ridx[i]) begin
      wr(ridx[i], 8'hff);
      rchk(ridx[i], rmsk[i]);
      wr(ridx[i], 8'h00);
    end
    wr(8'h20, 8'hff);
    rchk(8'h20, 8'h00);
    wr(IDX_LIVE, 8'hff);
    rchk(IDX_LIVE, 8'h00);
    chk("bus response", 1'b0, o_hresp);
    wr(IDX_SET_A, 8'd100);
    wr(IDX_CLR_A, 8'd90);
    wr(IDX_SET_B, 8'd10);
    wr(IDX_CLR_B, 8'd5);
    wr(IDX_HOLD0, 8'h03);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_ENABLE, 8'h01);
    level <= 9'd100;
    tick(6);
    chk("flags at level", 2'b10, o_peak_flag);
    chk("irq masked", 1'b0, o_irq);
    level <= 9'd101;
    tick(6);
    chk("flags above", 2'b11, o_peak_flag);
    chk("irq raised", 1'b1, o_irq);
    chk("filter input", IIR_PLUS, o_iir_in);
    level <= 9'd80;
    tick(5);
    chk("flag in hold", 2'b11, o_peak_flag);
    tick(1);
    chk("flag cleared", 2'b10, o_peak_flag);
    wr(IDX_IIR_SEL, 8'h01);
    tick(4);
    chk("three level zero", IIR_ZERO, o_iir_in);
    level <= 9'd0;
    tick(8);
    chk("three level minus", IIR_MINUS, o_iir_in);
    level <= 9'd200;
    tick(6);
    chk("three level plus", IIR_PLUS, o_iir_in);
    wr(IDX_IIR_SEL, 8'h00);
    level <= 9'd0;
    tick(10);
    chk("filter input low", IIR_ZERO, o_iir_in);
    rchk(IDX_IRQ_STAT, 8'h03);
    chk("irq sticky", 1'b1, o_irq);
    wr(IDX_IRQ_MASK, 8'h00);
    tick(1);
    chk("irq mask off", 1'b0, o_irq);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_IRQ_STAT, 8'h01);
    tick(1);
    chk("irq cleared", 1'b0, o_irq);
    rchk(IDX_IRQ_STAT, 8'h02);
    level <= 9'd200;
    tick(6);
    wr(IDX_ENABLE, 8'h00);
    tick(4);
    chk("flags off", 2'b00, o_peak_flag);
    level <= 9'd0;
    foreach (cidx[i]) wr(cidx[i], cdat[i]);
    for (int k = 0; k < 3; k++) begin
      call <= pall[k];
      calt <= palt[k];
      tick(40);
      chk("path0 compare", e0[k], o_path0_cmp);
      chk("path1 compare", e1[k], o_path1_cmp);
    end
    rchk(IDX_IRQ_STAT, 8'h0f);
    chk("alarm count", 8'd3, alarm_cnt);
    complete_run();
  end
endmodule // pcd_top_tb
